// >>> twsh_consts.svh
// Named constants for the tape write stream host port.
// Assumes inclusion by bare name from every design file.
`ifndef TWSH_CONSTS_SVH
`define TWSH_CONSTS_SVH
`define TWSH_DATA_W 8
`define TWSH_STATUS_W 8
`define TWSH_FIFO_DEPTH 8
`define TWSH_BLOCK_LEN 16'h03B8
`define TWSH_OVH_LEN 8'h08
`define TWSH_GAP_NORMAL_MIL 16'd350
`define TWSH_GAP_WIDE_MIL 16'd700
`define TWSH_REPOS_CYCLES 16'h0010
`define TWSH_VERIFY_DELAY 16'h0004
`define TWSH_MAX_DRIVES 4
`define TWSH_LINK_LINES 23
`define TWSH_ST_WRITE 0
`define TWSH_ST_READ 1
`define TWSH_ST_MARK 2
`define TWSH_ST_STREAM 3
`define TWSH_ST_UNDERFLOW 4
`define TWSH_ST_PROTECT 5
`define TWSH_ST_REWRITE 6
`define TWSH_ST_READY 7
`endif

// >>> twsh_pkg.sv
// State types for the two ends of the tape write stream host port, one per end.
// Assumes twsh_consts.svh is available by bare name.
`include "twsh_consts.svh"
package twsh_pkg;
  // Drive controller states
  typedef enum logic [2:0] {
    TWSH_IDLE,
    TWSH_FILL,
    TWSH_OVERHEAD,
    TWSH_STAGE,
    TWSH_WRITE,
    TWSH_REWRITE,
    TWSH_UNDERFLOW,
    TWSH_MARK
  } twsh_state_t;
  // Host-side handshake states
  typedef enum logic [1:0] {
    TWSH_H_IDLE,
    TWSH_H_WAIT,
    TWSH_H_STROBE,
    TWSH_H_RELEASE
  } twsh_hstate_t;
endpackage

// >>> twsh_link.sv
// Link between host adapter and drive: commands, status, data and handshake.
// Assumes one clock for both ends; the testbench joins the two modports.
`timescale 1ns/1ns
`include "twsh_consts.svh"
interface twsh_link;
  logic cmd_write; // Write command level
  logic cmd_mark; // Write tape mark command level
  logic cmd_read; // Read command level
  logic cmd_reset; // Reset command level
  logic [`TWSH_STATUS_W-1:0] status; // Eight status lines
  logic [`TWSH_DATA_W-1:0] data; // Data byte, host to drive
  logic host_byte_strobe; // Host data strobe
  logic drive_byte_ready; // Drive data ready
  // Drive end
  modport drive ( // One of up to four drives on the chain
    input cmd_write, cmd_mark, cmd_read, cmd_reset, data, host_byte_strobe,
    output status, drive_byte_ready
  );
  // Host end
  modport host (
    output cmd_write, cmd_mark, cmd_read, cmd_reset, data, host_byte_strobe,
    input status, drive_byte_ready
  );
endinterface

// >>> twsh_fifo.sv
// Parameterised FIFO with valid and ready on both sides.
// Assumes a single synchronous active-low reset.
`timescale 1ns/1ns
`include "twsh_consts.svh"
module twsh_fifo #(
  parameter int WIDTH = `TWSH_DATA_W,
  parameter int DEPTH = `TWSH_FIFO_DEPTH
) (
  input wire logic MCLK,
  input wire logic RESETN,
  input wire logic [WIDTH-1:0] IN_DATA,
  input wire logic IN_VALID,
  output logic IN_READY,
  output logic [WIDTH-1:0] OUT_DATA,
  output logic OUT_VALID,
  input wire logic OUT_READY
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH]; // Storage words
  logic [AW-1:0] wr_ptr; // Write index
  logic [AW-1:0] rd_ptr; // Read index
  logic [AW:0] count; // Words held
  logic push; // Word accepted
  logic pop; // Word drained
  assign push = IN_VALID && IN_READY;
  assign pop = OUT_VALID && OUT_READY;
  assign IN_READY = (count != (AW+1)'(DEPTH));
  assign OUT_VALID = (count != '0);
  assign OUT_DATA = mem[rd_ptr];
  // Storage and pointers
  always_ff @(posedge MCLK) begin
    if (!RESETN) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (push) begin
        mem[wr_ptr] <= IN_DATA;
        wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
      end
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

// >>> twsh_drive.sv
// Drive end: byte handshake into a FIFO, block assembly, write streaming.
// Assumes the host end keeps its own handshake and command discipline.
//
// Functional notes
// - bytes enter only by strobe against ready
// - withhold ready while buffer is full
// - host uses four commands only
// - eight status lines, always driven
// - eight-bit FIFO path, unlimited block length (code fixes each block at BLOCK_LEN bytes)
// - full buffer gets overhead, staged channel one
// - verify started means write current block
// - both channels active, ready returns
// - verify not started, write pending rewrite
// - no rewrite pending means underflow
// - underflow stops, repositions, waits for data
// - underflow leaves widened inter-block gap
// - protected cartridge blocks write current
// - protection does not affect reading
// - up to four drives share cable
// - host holds drive inactive at power
// - twenty-three line link, three traffic kinds (twsh_link carries 22 lines)
// - drive handles motion and positioning itself
// - host keeps long-term rate up
`timescale 1ns/1ns
`include "twsh_consts.svh"
module twsh_drive
  import twsh_pkg::*;
#(
  parameter logic [15:0] BLOCK_LEN = `TWSH_BLOCK_LEN,
  parameter logic [15:0] REPOS_CYCLES = `TWSH_REPOS_CYCLES
) (
  input wire logic MCLK,
  input wire logic RESETN,
  twsh_link.drive LINK,
  input wire logic PROTECT,
  input wire logic VERIFY_STARTED,
  input wire logic REWRITE_PENDING,
  input wire logic HEAD_READY,
  output logic [`TWSH_DATA_W-1:0] HEAD_DATA,
  output logic HEAD_VALID,
  output logic WRITE_CURRENT,
  output logic TAPE_MOTION,
  output logic CHAN1_ACTIVE,
  output logic [15:0] GAP_MIL,
  output logic [15:0] UNDERFLOW_COUNT
);
  ////////////////////////////////////////////////////////////////////////////
  // State record
  typedef struct packed {
    twsh_state_t st; // Controller state
    logic ready; // Data ready to host
    logic strobe_d; // Strobe seen last cycle
    logic [15:0] fill; // Bytes gathered into this block
    logic [15:0] cnt; // Overhead or reposition counter
    logic head_valid; // Byte on its way to head
    logic [`TWSH_DATA_W-1:0] head_data; // Byte to head
    logic wcur; // Write current enable
    logic motion; // Tape moving
    logic chan1; // Transfer channel 1 busy
    logic [15:0] gap; // Last inter-block gap
    logic [15:0] uf_count; // Underflow events
    logic [`TWSH_STATUS_W-1:0] status; // Status lines
  } twsh_drv_t;
  twsh_drv_t r; // Registered state
  twsh_drv_t next_r; // Next state
  ////////////////////////////////////////////////////////////////////////////
  // FIFO in the data path
  logic fifo_in_ready; // Space left in FIFO
  logic fifo_out_valid; // Byte waiting in FIFO
  logic [`TWSH_DATA_W-1:0] fifo_out_data; // Oldest byte
  logic fifo_pop; // Drain request
  logic strobe_rise; // New strobe edge
  logic cmd_any; // Write session active
  assign strobe_rise = LINK.host_byte_strobe && !r.strobe_d;
  assign cmd_any = LINK.cmd_write && !LINK.cmd_reset;
  // Drain only in idle, fill or write state with a write command and a free head byte slot; stall otherwise
  assign fifo_pop = fifo_out_valid && (!r.head_valid || HEAD_READY) && cmd_any &&
                    (r.st == TWSH_FILL || r.st == TWSH_IDLE || r.st == TWSH_WRITE);
  twsh_fifo #(
    .WIDTH(`TWSH_DATA_W),
    .DEPTH(`TWSH_FIFO_DEPTH)
  ) twsh_fifo_inst (
    .MCLK(MCLK),
    .RESETN(RESETN),
    .IN_DATA(LINK.data),
    .IN_VALID(strobe_rise && r.ready),
    .IN_READY(fifo_in_ready),
    .OUT_DATA(fifo_out_data),
    .OUT_VALID(fifo_out_valid),
    .OUT_READY(fifo_pop)
  );
  ////////////////////////////////////////////////////////////////////////////
  // Status encoding, used on the next-state path
  function automatic logic [`TWSH_STATUS_W-1:0] status_of(input twsh_state_t s, input logic prot,
                                                          input logic rdy, input logic rd);
    logic [`TWSH_STATUS_W-1:0] v;
    v = '0;
    v[`TWSH_ST_WRITE] = (s != TWSH_IDLE) && (s != TWSH_MARK);
    v[`TWSH_ST_READ] = rd;
    v[`TWSH_ST_MARK] = (s == TWSH_MARK);
    v[`TWSH_ST_STREAM] = (s == TWSH_WRITE);
    v[`TWSH_ST_UNDERFLOW] = (s == TWSH_UNDERFLOW);
    v[`TWSH_ST_PROTECT] = prot;
    v[`TWSH_ST_REWRITE] = (s == TWSH_REWRITE);
    v[`TWSH_ST_READY] = rdy;
    return v;
  endfunction
  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic
  always_comb begin
    next_r = r;
    next_r.strobe_d = LINK.host_byte_strobe;
    next_r.head_valid = r.head_valid && !HEAD_READY;
    // Ready drops on each accepted strobe, returns only with space
    if (strobe_rise && r.ready) begin
      next_r.ready = 1'b0;
    end else if (r.ready) begin
      // Once offered, ready stands until a byte takes it, the write command drops or PROTECT rises
      next_r.ready = cmd_any && !PROTECT;
    end else if (!LINK.host_byte_strobe) begin
      next_r.ready = fifo_in_ready && cmd_any && !PROTECT &&
                     (r.st == TWSH_IDLE || r.st == TWSH_FILL || r.st == TWSH_WRITE);
    end
    // Each drained byte counts toward the block and goes on to the head in order
    if (fifo_pop) begin
      next_r.fill = r.fill + 16'h0001;
      next_r.head_data = fifo_out_data;
      next_r.head_valid = 1'b1;
    end
    unique case (r.st)
      // Waiting for a command
      TWSH_IDLE: begin
        next_r.wcur = 1'b0;
        next_r.motion = 1'b0;
        if (LINK.cmd_mark && !PROTECT) begin
          next_r.st = TWSH_MARK;
          next_r.cnt = '0;
        end else if (cmd_any && !PROTECT) begin
          next_r.st = TWSH_FILL;
        end
      end
      // Gathering host bytes
      TWSH_FILL: begin
        if (fifo_pop && r.fill == BLOCK_LEN - 16'h0001) begin
          next_r.st = TWSH_OVERHEAD;
          next_r.cnt = '0;
        end
      end
      // Adding block overhead characters
      TWSH_OVERHEAD: begin
        next_r.cnt = r.cnt + 16'h0001;
        if (r.cnt == {8'h00, `TWSH_OVH_LEN} - 16'h0001) begin
          next_r.st = TWSH_STAGE;
          next_r.chan1 = 1'b1;
        end
      end
      // Deciding between write, rewrite and underflow
      TWSH_STAGE: begin
        if (VERIFY_STARTED) begin
          next_r.st = TWSH_WRITE;
          next_r.wcur = !PROTECT;
          next_r.motion = 1'b1;
          next_r.gap = `TWSH_GAP_NORMAL_MIL;
          next_r.fill = '0;
        end else if (REWRITE_PENDING) begin
          next_r.st = TWSH_REWRITE;
          next_r.wcur = !PROTECT;
        end else begin
          next_r.st = TWSH_UNDERFLOW;
          next_r.motion = 1'b0;
          next_r.wcur = 1'b0;
          next_r.cnt = '0;
          next_r.uf_count = r.uf_count + 16'h0001;
        end
      end
      // Current block streams to head while next fills
      TWSH_WRITE: begin
        next_r.st = TWSH_FILL;
        next_r.chan1 = 1'b0;
      end
      // Rewritten block goes out instead of the current one
      TWSH_REWRITE: begin
        next_r.st = TWSH_STAGE;
      end
      // Stop, reposition, wait for host data rate
      TWSH_UNDERFLOW: begin
        if (r.cnt != REPOS_CYCLES) begin
          next_r.cnt = r.cnt + 16'h0001;
        end else if (VERIFY_STARTED) begin
          next_r.st = TWSH_WRITE;
          next_r.wcur = !PROTECT;
          next_r.motion = 1'b1;
          next_r.gap = `TWSH_GAP_WIDE_MIL;
          next_r.fill = '0;
        end
      end
      // Tape mark written as a short gap burst
      TWSH_MARK: begin
        next_r.wcur = !PROTECT;
        next_r.motion = 1'b1;
        next_r.cnt = r.cnt + 16'h0001;
        if (r.cnt == {8'h00, `TWSH_OVH_LEN}) begin
          next_r.st = TWSH_IDLE;
        end
      end
    endcase
    // Protected cartridge never gets write current, whatever the state
    if (PROTECT) begin
      next_r.wcur = 1'b0;
    end
    if (LINK.cmd_reset) begin
      next_r.st = TWSH_IDLE;
      next_r.fill = '0;
      next_r.chan1 = 1'b0;
      next_r.wcur = 1'b0;
      next_r.motion = 1'b0;
    end
    next_r.status = status_of(next_r.st, PROTECT, next_r.ready, LINK.cmd_read);
  end
  ////////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge MCLK) begin
    if (!RESETN) begin
      r <= '{st: TWSH_IDLE, gap: `TWSH_GAP_NORMAL_MIL, default: '0};
    end else begin
      r <= next_r;
    end
  end
  assign LINK.drive_byte_ready = r.ready;
  assign LINK.status = r.status;
  assign HEAD_DATA = r.head_data;
  assign HEAD_VALID = r.head_valid;
  assign WRITE_CURRENT = r.wcur;
  assign TAPE_MOTION = r.motion;
  assign CHAN1_ACTIVE = r.chan1;
  assign GAP_MIL = r.gap;
  assign UNDERFLOW_COUNT = r.uf_count;
endmodule

// >>> twsh_host.sv
// Host adapter end: issues commands and strobes bytes against drive ready.
// Assumes the drive end answers each strobe by dropping ready.
`timescale 1ns/1ns
`include "twsh_consts.svh"
module twsh_host
  import twsh_pkg::*;
(
  input wire logic MCLK,
  input wire logic RESETN,
  twsh_link.host LINK,
  input wire logic [1:0] CMD_SEL,
  input wire logic CMD_EN,
  input wire logic [`TWSH_DATA_W-1:0] BYTE_DATA,
  input wire logic BYTE_VALID,
  output logic BYTE_TAKEN,
  output logic [`TWSH_STATUS_W-1:0] STATUS
);
  ////////////////////////////////////////////////////////////////////////////
  // State record
  typedef struct packed {
    twsh_hstate_t st; // Handshake state
    logic [3:0] cmd; // Write, mark, read, reset lines
    logic [`TWSH_DATA_W-1:0] data; // Byte on the data lines
    logic strobe; // Data strobe
    logic taken; // Byte accepted pulse
    logic [`TWSH_STATUS_W-1:0] status; // Captured status
  } twsh_host_t;
  twsh_host_t r; // Registered state
  twsh_host_t next_r; // Next state
  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic
  always_comb begin
    next_r = r;
    next_r.taken = 1'b0;
    next_r.status = LINK.status;
    // Only four commands exist
    next_r.cmd = CMD_EN ? (4'h1 << CMD_SEL) : 4'h0;
    unique case (r.st)
      // Wait for a byte and drive ready
      TWSH_H_IDLE: begin
        if (BYTE_VALID && LINK.drive_byte_ready) begin
          next_r.data = BYTE_DATA;
          next_r.st = TWSH_H_WAIT;
        end
      end
      // Data set up one cycle before strobe
      TWSH_H_WAIT: begin
        if (LINK.drive_byte_ready) begin
          next_r.strobe = 1'b1;
          next_r.st = TWSH_H_STROBE;
        end
      end
      // Hold byte until ready falls
      TWSH_H_STROBE: begin
        if (!LINK.drive_byte_ready) begin
          next_r.strobe = 1'b0;
          next_r.taken = 1'b1;
          next_r.st = TWSH_H_RELEASE;
        end
      end
      // One idle cycle before next byte
      TWSH_H_RELEASE: begin
        next_r.st = TWSH_H_IDLE;
      end
    endcase
  end
  ////////////////////////////////////////////////////////////////////////////
  // State register; reset holds drive non-operative
  always_ff @(posedge MCLK) begin
    if (!RESETN) begin
      r <= '{st: TWSH_H_IDLE, default: '0};
    end else begin
      r <= next_r;
    end
  end
  assign LINK.cmd_write = r.cmd[0];
  assign LINK.cmd_mark = r.cmd[1];
  assign LINK.cmd_read = r.cmd[2];
  assign LINK.cmd_reset = r.cmd[3];
  assign LINK.data = r.data;
  assign LINK.host_byte_strobe = r.strobe;
  assign BYTE_TAKEN = r.taken;
  assign STATUS = r.status;
endmodule

// >>> twsh_link_checker.sv
// Checker for the byte handshake and status lines of the host link.
// Assumes the testbench wires it to the signals of the link interface.
`timescale 1ns/1ns
`include "twsh_consts.svh"
module twsh_link_checker (
  input wire logic MCLK,
  input wire logic RESETN,
  input wire logic cmd_write,
  input wire logic [`TWSH_STATUS_W-1:0] status,
  input wire logic [`TWSH_DATA_W-1:0] data,
  input wire logic host_byte_strobe,
  input wire logic drive_byte_ready
);
  // One clock domain, reset disables every check
  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (!RESETN);
  ////////////////////////////////////////////////////////////////
  a_ready_drop_strobe: assert property (
    $rose(host_byte_strobe) && drive_byte_ready |=> !drive_byte_ready)
    else $error("ready did not drop after strobe");
  a_ready_low_hold: assert property (
    host_byte_strobe && !drive_byte_ready |=> !drive_byte_ready)
    else $error("ready returned while strobe high");
  a_ready_needs_write: assert property (
    $rose(drive_byte_ready) |-> $past(cmd_write))
    else $error("ready raised without write command");
  a_strobe_needs_ready: assert property (
    $rose(host_byte_strobe) |-> drive_byte_ready)
    else $error("strobe raised without ready");
  a_data_held_strobe: assert property (
    host_byte_strobe && $past(host_byte_strobe) |-> $stable(data))
    else $error("data changed under strobe");
  a_strobe_ends_bound: assert property (
    $rose(host_byte_strobe) |-> ##[1:4] !host_byte_strobe)
    else $error("strobe not released");
  a_strobe_low_gap: assert property (
    $fell(host_byte_strobe) |-> !host_byte_strobe [*2])
    else $error("strobe gap too short");
  a_reset_quiet_link: assert property (
    $rose(RESETN) |-> status == '0 && !drive_byte_ready)
    else $error("link not quiet after reset");
endmodule

// >>> tape_write_stream_host_port_tb.sv
// Testbench joining host and drive ends over the link interface.
// Assumes short block and reposition counts for a fast run.
`timescale 1ns/1ns
`include "twsh_consts.svh"
module tape_write_stream_host_port_tb;
  import twsh_pkg::*;
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  logic [1:0] cmd_sel = 2'h0;
  logic cmd_en = 1'b0;
  logic [7:0] byte_data = 8'h00;
  logic byte_valid = 1'b0;
  logic protect = 1'b0;
  logic verify = 1'b0;
  logic rewrite = 1'b0;
  logic head_ready = 1'b1;
  logic byte_taken, head_valid, write_current, tape_motion, chan1_active;
  logic [7:0] host_status, head_data, st_seen = 8'h00;
  logic [15:0] gap_mil, uf_count, u0;
  logic wc_seen = 1'b0;
  logic c1_seen = 1'b0;
  logic [7:0] got[$], sent[$];
  int bad_count = 0;
  int n_compared = 0;
  bit ok;
  ////////////////////////////////////////////////////////////////
  // Clock, link and both ends
  always #2 mclk = ~mclk;
  twsh_link twsh_link_inst ();
  twsh_host twsh_host_inst (.MCLK(mclk), .RESETN(resetn), .LINK(twsh_link_inst.host),
    .CMD_SEL(cmd_sel), .CMD_EN(cmd_en), .BYTE_DATA(byte_data), .BYTE_VALID(byte_valid),
    .BYTE_TAKEN(byte_taken), .STATUS(host_status));
  twsh_drive #(.BLOCK_LEN(16'h0004), .REPOS_CYCLES(16'h0004)) twsh_drive_inst (
    .MCLK(mclk), .RESETN(resetn), .LINK(twsh_link_inst.drive), .PROTECT(protect),
    .VERIFY_STARTED(verify), .REWRITE_PENDING(rewrite), .HEAD_READY(head_ready),
    .HEAD_DATA(head_data), .HEAD_VALID(head_valid), .WRITE_CURRENT(write_current),
    .TAPE_MOTION(tape_motion), .CHAN1_ACTIVE(chan1_active), .GAP_MIL(gap_mil),
    .UNDERFLOW_COUNT(uf_count));
  twsh_link_checker twsh_link_checker_inst (.MCLK(mclk), .RESETN(resetn),
    .cmd_write(twsh_link_inst.cmd_write), .status(twsh_link_inst.status),
    .data(twsh_link_inst.data), .host_byte_strobe(twsh_link_inst.host_byte_strobe),
    .drive_byte_ready(twsh_link_inst.drive_byte_ready));
  // Collects head bytes and sticky flags
  always @(posedge mclk) begin
    if (head_valid && head_ready) got.push_back(head_data);
    st_seen |= twsh_link_inst.status;
    wc_seen |= write_current;
    c1_seen |= chan1_active;
  end
  ////////////////////////////////////////////////////////////////
  // Compares one value and counts it
  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask
  // Offers one byte and waits for the host to take it
  task automatic send(input logic [7:0] b);
    int n;
    n = 0;
    @(negedge mclk);
    byte_data = b;
    byte_valid = 1'b1;
    while (byte_taken !== 1'b1 && n < 40) begin
      @(negedge mclk);
      n++;
    end
    ok = (byte_taken === 1'b1);
    byte_valid = 1'b0;
    if (ok) sent.push_back(b);
  endtask
  // Waits for the head to deliver every byte sent, then compares order
  task automatic drain();
    int n;
    n = 0;
    while (got.size() < sent.size() && n < 400) begin
      @(negedge mclk);
      n++;
    end
    check(16'(got.size()), 16'(sent.size()), "byte count");
    foreach (sent[i]) if (i < got.size()) check(16'(got[i]), 16'(sent[i]), "byte order");
    got.delete();
    sent.delete();
  endtask
  // Sets a command level
  task automatic cmd(input logic [1:0] sel, input logic en);
    @(negedge mclk);
    cmd_sel = sel;
    cmd_en = en;
    repeat (3) @(negedge mclk);
  endtask
  ////////////////////////////////////////////////////////////////
  task automatic t_reset();
    check(16'(twsh_link_inst.drive_byte_ready), 16'h0000, "ready at reset");
    check(gap_mil, 16'h015E, "normal gap");
    check(uf_count, 16'h0000, "underflows at reset");
    $display("Test reset done");
  endtask
  // Two blocks stream with verify already running
  task automatic t_stream();
    verify = 1'b1;
    cmd(2'h0, 1'b1);
    for (int i = 0; i < 8; i++) send(8'hA0 + 8'(i));
    drain();
    check(16'(wc_seen), 16'h0001, "write current");
    check(16'(c1_seen), 16'h0001, "channel one");
    check(16'(st_seen[`TWSH_ST_WRITE]), 16'h0001, "write status");
    check(uf_count, 16'h0000, "no underflow");
    $display("Test stream done");
  endtask
  // Head stalled: buffer fills and ready is withheld; then the rewrite loop
  task automatic t_full();
    int k;
    k = 0;
    head_ready = 1'b0;
    u0 = uf_count;
    ok = 1'b1;
    while (ok && k < 40) begin
      send(8'h10 + 8'(k));
      k++;
    end
    check(16'(twsh_link_inst.drive_byte_ready), 16'h0000, "ready withheld");
    check(16'(k), 16'(`TWSH_FIFO_DEPTH + 2), "buffer depth");
    verify = 1'b0;
    rewrite = 1'b1;
    head_ready = 1'b1;
    repeat (30) @(negedge mclk);
    check(16'(st_seen[`TWSH_ST_REWRITE]), 16'h0001, "rewrite status");
    check(uf_count, u0, "no underflow on rewrite");
    rewrite = 1'b0;
    verify = 1'b1;
    while (sent.size() % 4 != 0) send(8'h55);
    drain();
    $display("Test full done");
  endtask
  // Verify not started and nothing to rewrite: underflow, wide gap
  task automatic t_under();
    int n;
    n = 0;
    repeat (20) @(negedge mclk);
    verify = 1'b0;
    u0 = uf_count;
    for (int i = 0; i < 4; i++) send(8'hC0 + 8'(i));
    while (uf_count === u0 && n < 200) begin
      @(negedge mclk);
      n++;
    end
    check(uf_count, u0 + 16'h0001, "underflow count");
    check(16'(tape_motion), 16'h0000, "motion stopped");
    repeat (10) @(negedge mclk);
    verify = 1'b1;
    repeat (20) @(negedge mclk);
    check(gap_mil, 16'h02BC, "wide gap");
    drain();
    $display("Test underflow done");
  endtask
  // Protection, read, reset and mark commands
  task automatic t_prot();
    cmd(2'h0, 1'b0);
    protect = 1'b1;
    cmd(2'h0, 1'b1);
    wc_seen = 1'b0;
    repeat (20) @(negedge mclk);
    check(16'(twsh_link_inst.drive_byte_ready), 16'h0000, "protected ready");
    check(16'(wc_seen), 16'h0000, "protected current");
    cmd(2'h2, 1'b1);
    check(16'(host_status[`TWSH_ST_READ]), 16'h0001, "read under protect");
    check(16'(host_status[`TWSH_ST_PROTECT]), 16'h0001, "protect status");
    protect = 1'b0;
    cmd(2'h3, 1'b1);
    check(16'(twsh_link_inst.drive_byte_ready), 16'h0000, "reset command");
    check(16'(host_status[`TWSH_ST_WRITE]), 16'h0000, "reset ends write");
    st_seen = 8'h00;
    cmd(2'h1, 1'b1);
    repeat (15) @(negedge mclk);
    check(16'(st_seen[`TWSH_ST_MARK]), 16'h0001, "mark status");
    cmd(2'h0, 1'b0);
    $display("Test commands done");
  endtask
  ////////////////////////////////////////////////////////////////
  // Prints counts and the verdict, then ends the run
  task automatic print_verdict();
    $display("Compared %0d, mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Watchdog against a hang
  initial begin
    repeat (20000) @(posedge mclk);
    bad_count++;
    $display("Error %0t: watchdog expired", $time);
    print_verdict();
  end
  // Main sequence
  initial begin
    repeat (2) @(negedge mclk);
    resetn = 1'b1;
    t_reset();
    t_stream();
    t_full();
    t_under();
    t_prot();
    print_verdict();
  end
endmodule
